// File: hdl/gnc_pkg.sv
package gnc_pkg;

    localparam int unsigned NIB_W = 4;
    localparam int unsigned CODE_W = 5;

    // reset values
    localparam logic [4:0] CODE_RST = 5'h00;
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [2:0] CNT_RST = 3'h0;

    // bit counter: five clocks per codeword, last index four
    localparam logic [2:0] CNT_LAST = 3'h4;
    localparam logic [2:0] CNT_STEP = 3'h1;

    // all ones is the illegal sync pattern
    localparam logic [4:0] SYNC_MARK = 5'h1F;

    // mode select codes {mode_select_hi, mode_select_lo}
    localparam logic [1:0] MODE_SHIFT_IN = 2'h0;
    localparam logic [1:0] MODE_ENCODE = 2'h1;
    localparam logic [1:0] MODE_SHIFT_OUT = 2'h2;
    localparam logic [1:0] MODE_DECODE = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ENCODE = 3'h1,
        ST_SHIFT_OUT = 3'h2,
        ST_SHIFT_IN = 3'h3,
        ST_DECODE = 3'h4
    } gnc_state_t;

    typedef struct packed {
        logic enable_n;
        logic mode_select_hi;
        logic mode_select_lo;
    } gnc_ctrl_t;

    typedef struct packed {
        logic [3:0] nibble;
        logic invalid_code_flag;
        logic bit_sync_detect;
    } gnc_rx_t;

    function automatic logic [4:0] gnc_encode(input logic [3:0] n);
        logic [4:0] c;
        c = 5'h00;
        case (n)
            4'h0: c = 5'h19;
            4'h1: c = 5'h1B;
            4'h2: c = 5'h12;
            4'h3: c = 5'h13;
            4'h4: c = 5'h1D;
            4'h5: c = 5'h15;
            4'h6: c = 5'h16;
            4'h7: c = 5'h17;
            4'h8: c = 5'h1A;
            4'h9: c = 5'h09;
            4'hA: c = 5'h0A;
            4'hB: c = 5'h0B;
            4'hC: c = 5'h1E;
            4'hD: c = 5'h0D;
            4'hE: c = 5'h0E;
            default: c = 5'h0F;
        endcase
        return c;
    endfunction : gnc_encode

    // unused patterns decode to zero, flagged separately
    function automatic logic [3:0] gnc_decode(input logic [4:0] c);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (gnc_encode(4'(i)) == c) begin
                n = 4'(i);
            end
        end
        return n;
    endfunction : gnc_decode

    function automatic logic gnc_valid(input logic [4:0] c);
        logic v;
        v = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (gnc_encode(4'(i)) == c) begin
                v = 1'b1;
            end
        end
        return v;
    endfunction : gnc_valid

    // write register holds the word end for end, msb in bit 0
    function automatic logic [4:0] gnc_reverse(input logic [4:0] c);
        return {c[0], c[1], c[2], c[3], c[4]};
    endfunction : gnc_reverse

endpackage : gnc_pkg

// File: hdl/gnc_sync.sv
`timescale 1ns/100ps
module gnc_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;

    // first stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : gnc_sync

// File: hdl/gnc_toggle_rx.sv
`timescale 1ns/100ps
module gnc_toggle_rx (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tog_i,
    output logic pulse_o
);
    logic tog_s;
    logic tog_d;

    gnc_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(tog_i),
        .q_o(tog_s)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tog_d <= 1'b0;
        end else begin
            tog_d <= tog_s;
        end
    end

    // one cycle per toggle of the far side
    assign pulse_o = tog_s ^ tog_d;
endmodule : gnc_toggle_rx

// File: hdl/gnc_top.sv
`timescale 1ns/100ps
module gnc_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic rd_clk_i,
    input wire logic wr_clk_i,
    input wire gnc_pkg::gnc_ctrl_t ctrl_i,
    input wire logic invalid_flag_control_i,
    input wire logic [3:0] nibble_i,
    input wire logic serial_read_input_i,
    output logic serial_write_o,
    output gnc_pkg::gnc_rx_t rx_o,
    output gnc_pkg::gnc_state_t state_o,
    output logic word_sent_o,
    output logic word_ready_o
);
    import gnc_pkg::*;

    gnc_state_t state;
    gnc_state_t next_state;
    logic [1:0] mode;
    logic [3:0] nibble_hold;
    logic wr_load_tog;
    logic shift_out_req;
    logic shift_in_req;
    logic [4:0] rd_word_hold;
    logic [3:0] rx_nibble;
    logic invalid_code_flag;
    logic rd_word_pulse;
    logic sync_s;
    logic first_decode;

    logic wr_load_pulse;
    logic wr_shift_lvl;
    logic [4:0] wr_reg;
    logic [2:0] wr_cnt;
    logic wr_done_tog;
    logic [4:0] enc_now;

    logic rd_shift_lvl;
    logic [4:0] rd_reg;
    logic [2:0] rd_cnt;
    logic [4:0] rd_word;
    logic rd_word_tog;
    logic rd_sync;

    assign mode = {ctrl_i.mode_select_hi, ctrl_i.mode_select_lo};
    assign enc_now = gnc_encode(nibble_hold);

    always_comb begin
        next_state = ST_IDLE;
        if (!ctrl_i.enable_n) begin
            case (mode)
                MODE_SHIFT_IN: next_state = ST_SHIFT_IN;
                MODE_ENCODE: next_state = ST_ENCODE;
                MODE_SHIFT_OUT: next_state = ST_SHIFT_OUT;
                MODE_DECODE: next_state = ST_DECODE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end
    assign state_o = state;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            nibble_hold <= NIB_RST;
            wr_load_tog <= 1'b0;
        end else if (next_state == ST_ENCODE && state != ST_ENCODE) begin
            nibble_hold <= nibble_i;
            wr_load_tog <= ~wr_load_tog;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_out_req <= 1'b0;
            shift_in_req <= 1'b0;
        end else begin
            shift_out_req <= (next_state == ST_SHIFT_OUT);
            shift_in_req <= (next_state == ST_SHIFT_IN);
        end
    end

    // words from the read side stay still for five read clocks
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_word_hold <= CODE_RST;
        end else if (rd_word_pulse) begin
            rd_word_hold <= rd_word;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_nibble <= NIB_RST;
        end else if (state == ST_DECODE) begin
            rx_nibble <= gnc_decode(rd_word_hold);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            invalid_code_flag <= 1'b0;
        end else if (!invalid_flag_control_i) begin
            invalid_code_flag <= 1'b0;
        end else if (state == ST_DECODE) begin
            invalid_code_flag <= ~gnc_valid(rd_word_hold);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            first_decode <= 1'b0;
        end else begin
            first_decode <= (state == ST_DECODE) && (next_state != ST_DECODE);
        end
    end
    assign word_ready_o = first_decode;

    assign rx_o.nibble = rx_nibble;
    assign rx_o.invalid_code_flag = invalid_code_flag;
    assign rx_o.bit_sync_detect = sync_s;

    gnc_toggle_rx u_rd_word (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .tog_i(rd_word_tog),
        .pulse_o(rd_word_pulse)
    );

    gnc_toggle_rx u_wr_done (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .tog_i(wr_done_tog),
        .pulse_o(word_sent_o)
    );

    gnc_sync u_sync_bs (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(rd_sync),
        .q_o(sync_s)
    );

    gnc_toggle_rx u_wr_load (
        .clk_i(wr_clk_i),
        .rst_i(rst_i),
        .tog_i(wr_load_tog),
        .pulse_o(wr_load_pulse)
    );

    gnc_sync u_sync_wr (
        .clk_i(wr_clk_i),
        .rst_i(rst_i),
        .d_i(shift_out_req),
        .q_o(wr_shift_lvl)
    );

    always_ff @(posedge wr_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg <= CODE_RST;
        end else if (wr_load_pulse) begin
            wr_reg <= gnc_reverse(enc_now);
        end else if (wr_shift_lvl) begin
            wr_reg <= {wr_reg[0], wr_reg[4:1]};
        end
    end

    // one word per five write clocks
    always_ff @(posedge wr_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_cnt <= CNT_RST;
            wr_done_tog <= 1'b0;
        end else if (!wr_shift_lvl) begin
            wr_cnt <= CNT_RST;
        end else if (wr_cnt == CNT_LAST) begin
            wr_cnt <= CNT_RST;
            wr_done_tog <= ~wr_done_tog;
        end else begin
            wr_cnt <= wr_cnt + CNT_STEP;
        end
    end

    always_ff @(posedge wr_clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_write_o <= 1'b0;
        end else if (wr_load_pulse) begin
            serial_write_o <= enc_now[4];
        end else if (wr_shift_lvl) begin
            serial_write_o <= wr_reg[1];
        end else begin
            serial_write_o <= wr_reg[0];
        end
    end

    gnc_sync u_sync_rd (
        .clk_i(rd_clk_i),
        .rst_i(rst_i),
        .d_i(shift_in_req),
        .q_o(rd_shift_lvl)
    );

    always_ff @(posedge rd_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_reg <= CODE_RST;
        end else if (rd_shift_lvl) begin
            rd_reg <= {rd_reg[3:0], serial_read_input_i};
        end
    end

    always_ff @(posedge rd_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_cnt <= CNT_RST;
            rd_word <= CODE_RST;
            rd_word_tog <= 1'b0;
        end else if (!rd_shift_lvl) begin
            rd_cnt <= CNT_RST;
        end else if (rd_cnt == CNT_LAST) begin
            rd_cnt <= CNT_RST;
            rd_word <= {rd_reg[3:0], serial_read_input_i};
            rd_word_tog <= ~rd_word_tog;
        end else begin
            rd_cnt <= rd_cnt + CNT_STEP;
        end
    end

    always_ff @(posedge rd_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_sync <= 1'b0;
        end else begin
            rd_sync <= (rd_reg == SYNC_MARK);
        end
    end

    a_encode_table: assert property (
        @(posedge wr_clk_i) disable iff (rst_i)
        wr_load_pulse |=> gnc_reverse(wr_reg) == $past(enc_now))
    else $error("loaded codeword does not match nibble");

    a_no_zero_run: assert property (
        @(posedge wr_clk_i) disable iff (rst_i)
        wr_load_pulse |=> (wr_reg[2:0] != 3'h0) && (wr_reg[3:1] != 3'h0)
            && (wr_reg[4:2] != 3'h0))
    else $error("codeword holds three zeros in a row");

    a_msb_first: assert property (
        @(posedge wr_clk_i) disable iff (rst_i)
        wr_load_pulse |=> serial_write_o == $past(enc_now[4]))
    else $error("first serial bit is not the codeword msb");

    a_rotate_back: assert property (
        @(posedge wr_clk_i) disable iff (rst_i)
        (wr_shift_lvl && !wr_load_pulse) [*5]
            |=> wr_reg == $past(wr_reg, 5))
    else $error("register not restored after five rotations");

    a_shift_in_order: assert property (
        @(posedge rd_clk_i) disable iff (rst_i)
        rd_shift_lvl [*5] |=> rd_reg == {$past(serial_read_input_i, 5),
            $past(serial_read_input_i, 4), $past(serial_read_input_i, 3),
            $past(serial_read_input_i, 2), $past(serial_read_input_i, 1)})
    else $error("shift in order wrong");

    a_sync_mark: assert property (
        @(posedge rd_clk_i) disable iff (rst_i)
        (rd_reg == SYNC_MARK) |=> rd_sync)
    else $error("sync mark not indicated");

    // checked per domain: a mark can drop before the mclk side sees it
    a_sync_cross: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_sync [*3] |-> sync_s)
    else $error("sync mark lost in crossing");

    a_invalid_clear: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !invalid_flag_control_i |=> !invalid_code_flag)
    else $error("invalid flag not cleared");

    a_invalid_set: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (invalid_flag_control_i && state == ST_DECODE)
            |=> invalid_code_flag == !gnc_valid($past(rd_word_hold)))
    else $error("invalid flag does not follow codeword");

    a_decode_load: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state == ST_DECODE && gnc_valid(rd_word_hold))
            |=> gnc_encode(rx_nibble) == $past(rd_word_hold))
    else $error("decoded nibble wrong");

    a_idle_hold: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ctrl_i.enable_n |=> state == ST_IDLE ##1 $stable(rx_nibble))
    else $error("register changed while held");

    a_one_operation: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !(shift_out_req && shift_in_req) && !(wr_shift_lvl && rd_shift_lvl))
    else $error("read and write active together");

    a_word_count: assert property (
        @(posedge rd_clk_i) disable iff (rst_i)
        (rd_shift_lvl && rd_cnt == CNT_LAST) |=> $changed(rd_word_tog))
    else $error("word not published on fifth bit");

endmodule : gnc_top

// File: verif/gnc_link_model.sv
`timescale 1ns/100ps
module gnc_link_model (
    input wire logic rd_clk_i,
    input wire logic wr_clk_i,
    input wire logic start_i,
    input wire logic [4:0] word_i,
    input wire logic [2:0] lead_i,
    input wire logic serial_write_i,
    output logic serial_read_o,
    output logic [9:0] wr_hist_o
);
    int edge_n = 0;
    int pos = 0;

    initial serial_read_o = 1'b1;
    initial wr_hist_o = 10'h000;

    // data separator: edge_n numbers the read edge after which the bit is driven; the next read edge samples it
    always @(posedge rd_clk_i) begin
        #5;
        edge_n = start_i ? edge_n + 1 : 0;
        pos = edge_n - int'(lead_i);
        if (start_i && pos >= 0 && pos < 5)
            serial_read_o = word_i[4 - pos];
        else
            serial_read_o = 1'b1;
    end

    // write path just records the bit level seen at each write edge
    always @(posedge wr_clk_i) begin
        wr_hist_o <= {wr_hist_o[8:0], serial_write_i};
    end
endmodule : gnc_link_model

// File: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    import gnc_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rd_clk = 1'b0;
    logic wr_clk = 1'b0;
    gnc_ctrl_t ctrl = 3'h4;
    logic flag_ctl = 1'b1;
    logic [3:0] nibble = 4'h0;
    logic ser_rd;
    logic ser_wr;
    logic word_sent;
    logic word_ready;
    gnc_rx_t rx;
    gnc_state_t state;
    logic start = 1'b0;
    logic [4:0] word = 5'h1F;
    logic [2:0] lead = 3'h3;
    logic [9:0] hist;
    int n_errors = 0;
    int check_count = 0;
    int n_sent = 0;
    int n_ready = 0;
    // codeword per nibble, msb is the first bit on tape
    logic [4:0] tab [16] = '{5'h19, 5'h1B, 5'h12, 5'h13, 5'h1D, 5'h15,
        5'h16, 5'h17, 5'h1A, 5'h09, 5'h0A, 5'h0B, 5'h1E, 5'h0D, 5'h0E, 5'h0F};
    logic [4:0] bad [3] = '{5'h00, 5'h10, 5'h1C};

    always #12.5 mclk_i = ~mclk_i;
    // link clocks run free, phases unrelated to mclk and to each other
    initial begin
        #17;
        forever #40 rd_clk = ~rd_clk;
    end
    initial begin
        #31;
        forever #40 wr_clk = ~wr_clk;
    end

    gnc_top dut_u (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .rd_clk_i(rd_clk),
        .wr_clk_i(wr_clk),
        .ctrl_i(ctrl),
        .invalid_flag_control_i(flag_ctl),
        .nibble_i(nibble),
        .serial_read_input_i(ser_rd),
        .serial_write_o(ser_wr),
        .rx_o(rx),
        .state_o(state),
        .word_sent_o(word_sent),
        .word_ready_o(word_ready)
    );

    gnc_link_model link_u (
        .rd_clk_i(rd_clk),
        .wr_clk_i(wr_clk),
        .start_i(start),
        .word_i(word),
        .lead_i(lead),
        .serial_write_i(ser_wr),
        .serial_read_o(ser_rd),
        .wr_hist_o(hist)
    );

    always @(posedge mclk_i) begin
        if (word_sent === 1'b1) n_sent <= n_sent + 1;
        if (word_ready === 1'b1) n_ready <= n_ready + 1;
    end

    task automatic summarize;
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check

    // expected bit stream of a codeword rotating msb first from phase p
    function automatic logic [9:0] rot(input logic [4:0] c, input int p);
        logic [9:0] r;
        for (int j = 0; j < 10; j++) r[9 - j] = c[4 - ((p + j) % 5)];
        return r;
    endfunction : rot

    function automatic logic run_ok(input logic [9:0] h);
        for (int j = 0; j < 8; j++) if (h[j +: 3] === 3'b000) return 1'b0;
        return 1'b1;
    endfunction : run_ok

    task automatic set_ctrl(input logic [2:0] c, input gnc_state_t exp);
        @(posedge mclk_i);
        #2 ctrl = c;
        @(posedge mclk_i);
        #2 check(state === exp, "state after control change");
    endtask : set_ctrl

    task automatic write_word(input int n);
        logic [4:0] c;
        logic hit;
        int s0;
        c = tab[n];
        hit = 1'b0;
        nibble = 4'(n);
        set_ctrl(3'h1, ST_ENCODE);
        repeat (6) @(posedge wr_clk);
        #2 check(ser_wr === c[4], "first bit on write line");
        s0 = n_sent;
        set_ctrl(3'h2, ST_SHIFT_OUT);
        repeat (20) @(posedge wr_clk);
        #2;
        for (int p = 0; p < 5; p++) if (hist === rot(c, p)) hit = 1'b1;
        check(hit, "rotating write stream");
        check(run_ok(hist), "zero run on write line");
        set_ctrl(3'h4, ST_IDLE);
        repeat (16) @(posedge mclk_i);
        #2 check(n_sent - s0 == 4, "words sent");
    endtask : write_word

    task automatic read_word(input logic [4:0] w, input logic ctl);
        int r0;
        word = w;
        flag_ctl = ctl;
        @(posedge rd_clk);
        #3 start = 1'b1;
        set_ctrl(3'h0, ST_SHIFT_IN);
        repeat (int'(lead) + 4) @(posedge rd_clk);
        repeat (4) @(posedge mclk_i);
        r0 = n_ready;
        set_ctrl(3'h3, ST_DECODE);
        start = 1'b0;
        set_ctrl(3'h7, ST_IDLE);
        repeat (4) @(posedge mclk_i);
        #2 check(n_ready - r0 == 1, "one word per decode");
    endtask : read_word

    initial begin
        repeat (5) @(posedge mclk_i);
        #2 rst_i = 1'b0;
        repeat (4) @(posedge rd_clk);
        #2 check(state === ST_IDLE && rx === 6'h00, "after reset");
        // msb is taken on the third read edge after shift-in starts
        read_word(5'h0F, 1'b1);
        check(rx.nibble === 4'hF, "first read word");
        for (int n = 0; n < 16; n++) begin
            write_word(n);
            read_word(tab[n], 1'b1);
            check(rx.nibble === 4'(n), "decoded nibble");
            check(rx.invalid_code_flag === 1'b0, "valid word");
        end
        foreach (bad[i]) begin
            read_word(bad[i], 1'b1);
            check(rx.invalid_code_flag === 1'b1, "unused code");
        end
        flag_ctl = 1'b0;
        repeat (2) @(posedge mclk_i);
        #2 check(rx.invalid_code_flag === 1'b0, "flag cleared");
        read_word(5'h00, 1'b0);
        check(rx.invalid_code_flag === 1'b0, "flag held low");
        read_word(5'h1F, 1'b1);
        check(rx.bit_sync_detect === 1'b1, "sync mark");
        check(rx.invalid_code_flag === 1'b1, "violation");
        summarize();
    end

    // whole run needs well under 100 us; the margin covers slow handshakes
    initial begin
        #400000;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
endmodule : testbench
